// File: logic/deskew_pkg.sv
// shared types and constants for the deskew clock loop
`default_nettype none
package deskew_pkg;
  localparam int unsigned COUNT_W        = 8;      // width of the source period counter
  localparam int unsigned DIV_PROD_W     = 13;     // width of period times twice the factor
  localparam int unsigned LOCK_DROP_SRC  = 4;      // lock falls within this many source cycles
  localparam logic [3:0]  LOCK_PERIODS   = 4'h8;   // aligned source periods needed for lock
  localparam logic [7:0]  COUNT_RESET    = 8'h00;  // counters and taps after reset
  localparam logic [7:0]  COUNT_MAX      = 8'hff;  // period counter saturates here

  // loop flavour, one-hot
  typedef enum logic [2:0] {
    VARIANT_FULL  = 3'b001,  // full loop: all outputs
    VARIANT_HF    = 3'b010,  // high-frequency loop: no doubled output
    VARIANT_WRAP  = 3'b100   // simple wrapper: deskewed output only
  } variant_t;

  // lock tracking, one-hot
  typedef enum logic [1:0] {
    LOCK_SEEK = 2'b01,
    LOCK_HELD = 2'b10
  } lock_state_t;

  // divide factor selection: 1.5, 2, 2.5, 3, 4, 5, 8, 16
  typedef enum logic [2:0] {
    DIV_1P5 = 3'h0, DIV_2 = 3'h1, DIV_2P5 = 3'h2, DIV_3 = 3'h3,
    DIV_4   = 3'h4, DIV_5 = 3'h5, DIV_8   = 3'h6, DIV_16 = 3'h7
  } divide_factor_t;

  // the conditioned clocks travel together
  typedef struct packed {
    logic deskewed;  // 1x delay-compensated clock
    logic doubled;   // 2x clock once lock_indicator, 1x 25/75 before
    logic divided;   // source divided by the selected factor
  } clock_outs_t;

  // twice the divide factor, so the fractional factors stay integral; six bits hold 32
  function automatic logic [5:0] twice_factor(input divide_factor_t f);
    unique case (f)
      DIV_1P5: twice_factor = 6'h03;
      DIV_2:   twice_factor = 6'h04;
      DIV_2P5: twice_factor = 6'h05;
      DIV_3:   twice_factor = 6'h06;
      DIV_4:   twice_factor = 6'h08;
      DIV_5:   twice_factor = 6'h0a;
      DIV_8:   twice_factor = 6'h10;
      DIV_16:  twice_factor = 6'h20;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: logic/deskew_clock_dll.sv
// delay-lock_indicator clock conditioner: deskewed, doubled and divided clocks with lock
`default_nettype none
// Behaviour
// [R01] loop reset drops the lock indicator within four source cycles.
// [R02] loop reset is active high; user drives it dynamically or ties it low.
// [R03] during loop reset taps clear to zero; outputs may glitch and lose deskew.
// [R04] user resets loop on frequency change, scan reconfig, hot swap, unstable start.
// [R05] once lock_indicator the doubled output runs at twice the source, 50/50 duty.
// [R06] before lock the doubled output runs at 1x with 25/75 duty.
// [R07] high-frequency variant offers no doubled output.
// [R08] divided output runs at source over 1.5, 2, 2.5, 3, 4, 5, 8 or 16.
// [R09] divided output has 50/50 duty for every factor, fractional ones too.
// [R10] only the deskewed or the doubled output may be fed back.
// [R11] input-buffer feedback: external port, doubled fed back, output buffers only.
// [R12] wrapper variant gives a compensated 50/50 copy unless correction is off.
// [R13] wrapper variant exposes no reset, lock, multiply, divide or domain controls.
// [R14] source clock comes from a global buffer or same-edge clock input buffer.
// [R15] lock rises only after feedback aligns with source and holds while aligned.
module deskew_clock_dll
  import deskew_pkg::*;
(
  input  wire  logic                       i_clock,                 // system clock, 20 MHz
  input  wire  logic                       i_rst,                   // sync reset, active high
  input  wire  logic                       i_clk_en,                // freezes all state when low
  input  wire  deskew_pkg::variant_t       i_variant,               // loop flavour
  input  wire  logic                       i_source_clock_in,       // sampled source clock
  input  wire  logic                       i_feedback_clock_in,     // sampled feedback clock
  input  wire  logic                       i_loop_reset,            // loop reset, active high
  input  wire  logic                       i_duty_correct_en,       // 1 = duty correction on
  input  wire  deskew_pkg::divide_factor_t i_divide_factor_setting, // divided output factor
  output var   deskew_pkg::clock_outs_t    o_clocks,                // conditioned clocks
  output logic                             o_lock_indicator         // loop lock_indicator
);
  import deskew_pkg::*;

  logic                   src_d_reg, fb_d_reg;
  logic [COUNT_W-1:0]     cnt_reg, per_reg, tap_reg;
  logic [3:0]             good_reg;
  logic                   aligned_reg;
  lock_state_t            lock_reg;
  logic [DIV_PROD_W-1:0]  dv_cnt_reg;
  logic                   wrap_mode, loop_rst, src_rise, fb_rise;
  logic                   loop_clr, fb_seen_reg, fb_first;
  logic [COUNT_W:0]       phase_sum;
  logic [COUNT_W-1:0]     phase, half_per, quarter_per;
  logic [DIV_PROD_W-1:0]  dv_prod, dv_full, dv_half;
  clock_outs_t            clocks_next;

  // the wrapper has no loop reset pin, so the input is ignored there
  assign wrap_mode = (i_variant == VARIANT_WRAP);
  assign loop_rst  = i_loop_reset && !wrap_mode;  // [R13]
  assign src_rise  = i_source_clock_in && !src_d_reg;
  assign fb_rise   = i_feedback_clock_in && !fb_d_reg;
  // a loop reset seen while disabled waits for the enable, so state stays frozen
  assign loop_clr  = loop_rst && i_clk_en;
  // a fed-back doubled clock rises twice per period once lock_indicator;
  // only the first rise of a source period is weighed for skew
  assign fb_first  = fb_rise && (src_rise || !fb_seen_reg);

  // output phase is the source phase advanced by the tap setting
  always_comb begin
    phase_sum = {1'b0, cnt_reg} + {1'b0, tap_reg};
    if (phase_sum >= {1'b0, per_reg}) begin
      phase_sum = phase_sum - {1'b0, per_reg};
    end
    phase       = phase_sum[COUNT_W-1:0];
    half_per    = per_reg >> 1;
    quarter_per = per_reg >> 2;
    dv_prod     = DIV_PROD_W'(per_reg * twice_factor(i_divide_factor_setting));  // [R08]
    dv_full     = dv_prod >> 1;   // divided period in system cycles
    dv_half     = dv_prod >> 2;   // high time, half of the period [R09]
  end

  // edge history of the sampled clocks
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      src_d_reg <= 1'b0;
      fb_d_reg  <= 1'b0;
    end else if (i_clk_en) begin
      src_d_reg <= i_source_clock_in;
      fb_d_reg  <= i_feedback_clock_in;
    end
  end

  // first feedback rise of each source period; later rises in the same period
  // are the mid-period edge of a fed-back doubled clock, not skew
  always_ff @(posedge i_clock) begin
    if (i_rst || loop_clr) begin
      fb_seen_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (src_rise) begin
        fb_seen_reg <= fb_rise;
      end else if (fb_rise) begin
        fb_seen_reg <= 1'b1;
      end
    end
  end

  // source period measurement; counter saturates if the source stops
  // limitation: a source slower than the counter range is not measured correctly
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_reg <= COUNT_RESET;
      per_reg <= COUNT_RESET;
    end else if (i_clk_en) begin
      if (src_rise) begin
        cnt_reg <= COUNT_RESET;
        per_reg <= cnt_reg + 8'h01;
      end else if (cnt_reg != COUNT_MAX) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // delay tap: step one cycle toward alignment on each first feedback rise of a source period that misses the source edge
  // one step per source period keeps the loop from hunting;
  // the price is a slow lock after every loop reset
  always_ff @(posedge i_clock) begin
    if (i_rst || loop_clr) begin
      tap_reg <= COUNT_RESET;  // [R03]
    end else if (i_clk_en && fb_first && !src_rise && per_reg != COUNT_RESET) begin
      if (cnt_reg < half_per) begin
        // feedback late: advance the output
        tap_reg <= (tap_reg + 8'h01 >= per_reg) ? COUNT_RESET : tap_reg + 8'h01;
      end else begin
        // feedback early: retard the output
        tap_reg <= (tap_reg == COUNT_RESET) ? per_reg - 8'h01 : tap_reg - 8'h01;
      end
    end
  end

  // alignment seen within the current source period
  always_ff @(posedge i_clock) begin
    if (i_rst || loop_clr) begin
      aligned_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (src_rise) begin
        aligned_reg <= fb_first;
      end else if (fb_first) begin
        aligned_reg <= 1'b0;
      end
    end
  end

  // lock tracking; a misaligned feedback edge drops lock at once
  always_ff @(posedge i_clock) begin
    if (i_rst || loop_clr) begin
      lock_reg <= LOCK_SEEK;  // [R01]
      good_reg <= 4'h0;
    end else if (i_clk_en) begin
      unique case (lock_reg)
        LOCK_SEEK: begin
          if (src_rise) begin
            good_reg <= aligned_reg ? good_reg + 4'h1 : 4'h0;
            if (aligned_reg && good_reg + 4'h1 >= LOCK_PERIODS) begin
              lock_reg <= LOCK_HELD;  // [R15]
            end
          end
        end
        LOCK_HELD: begin
          // a source edge without feedback, or feedback off the source edge,
          // means alignment is gone
          if (fb_first != src_rise) begin
            lock_reg <= LOCK_SEEK;  // [R15]
            good_reg <= 4'h0;
          end
        end
        default: begin
          lock_reg <= LOCK_SEEK;
          good_reg <= 4'h0;
        end
      endcase
    end
  end

  // divided clock counter, restarted on the selected period
  // a factor change takes effect at once, so one odd period may follow it
  always_ff @(posedge i_clock) begin
    if (i_rst || loop_clr) begin
      dv_cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (dv_cnt_reg + 13'h0001 >= dv_full) begin
        dv_cnt_reg <= '0;
      end else begin
        dv_cnt_reg <= dv_cnt_reg + 13'h0001;
      end
    end
  end

  // deskewed and doubled waveforms from the corrected phase, divided from its counter
  always_comb begin
    // without correction the deskewed clock just follows the source
    clocks_next.deskewed = i_duty_correct_en ? (phase < half_per)
                                             : i_source_clock_in;  // [R12]
    if (lock_reg == LOCK_HELD) begin
      clocks_next.doubled = (phase < quarter_per) ||
                            (phase >= half_per && phase < half_per + quarter_per);  // [R05]
    end else begin
      clocks_next.doubled = (phase < quarter_per);  // [R06]
    end
    clocks_next.divided = (dv_cnt_reg < dv_half);  // [R09]
    if (i_variant != VARIANT_FULL) begin
      clocks_next.doubled = 1'b0;  // [R07]
    end
    if (wrap_mode) begin
      clocks_next.divided = 1'b0;  // [R13]
    end
  end

  // registered outputs; reset briefly disturbs the clocks, which is allowed
  // the wrapper has no lock pin, so lock is masked there
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_clocks         <= '0;
      o_lock_indicator <= 1'b0;
    end else if (i_clk_en) begin
      o_clocks         <= clocks_next;
      o_lock_indicator <= (lock_reg == LOCK_HELD) && !loop_rst && !wrap_mode;  // [R01]
    end
  end
endmodule
`default_nettype wire

// File: testbench/deskew_clock_dll_properties.sv
// port assertions for the deskew clock loop
`default_nettype none
module deskew_checker
  import deskew_pkg::*;
(
  input wire logic                    i_clock,         // clock
  input wire logic                    i_rst,           // reset
  input wire logic                    i_clk_en,        // run
  input wire deskew_pkg::variant_t    i_variant,       // flavour
  input wire logic                    i_loop_reset,    // loop reset
  input wire deskew_pkg::clock_outs_t o_clocks,        // clocks
  input wire logic                    o_lock_indicator // lock
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // enabled cycles of loop reset, wrapper and high-frequency flavour
  logic lr, ew, eh;
  assign lr = i_clk_en && i_loop_reset && i_variant != VARIANT_WRAP;
  assign ew = i_clk_en && i_variant == VARIANT_WRAP;
  assign eh = i_clk_en && i_variant == VARIANT_HF;
  a_drop_lock: assert property (lr |=> !o_lock_indicator)
    else $error("lock kept in loop reset");
  a_lock_low_rst: assert property (lr [*2] |-> !o_lock_indicator)
    else $error("lock high in loop reset");
  a_hf_no_dbl: assert property (eh [*2] |-> !o_clocks.doubled)
    else $error("doubled clock in high-freq loop");
  a_wrap_no_lock: assert property (ew [*2] |-> !o_lock_indicator)
    else $error("lock shown by wrapper");
  a_wrap_no_div: assert property (ew [*2] |-> !o_clocks.divided)
    else $error("divided clock from wrapper");
  a_lock_rise: assert property ($rose(o_lock_indicator) |-> !$past(i_loop_reset))
    else $error("lock rose out of loop reset");
  a_out_frozen: assert property (!i_clk_en |=> $stable(o_clocks) && $stable(o_lock_indicator))
    else $error("outputs moved while disabled");
  a_reset_idle: assert property (disable iff (1'b0) i_rst |=> o_clocks == 3'h0 && !o_lock_indicator)
    else $error("outputs busy after reset");
endmodule
bind deskew_clock_dll deskew_checker i_deskew_checker (.i_clock, .i_rst, .i_clk_en,
  .i_variant, .i_loop_reset, .o_clocks, .o_lock_indicator);
`default_nettype wire

// File: testbench/clock_net_model.sv
// clock network model: free-running source and feedback path
`default_nettype none
module clock_net_model
  import deskew_pkg::*;
#(
  parameter int HALF = 8  // source half period in system cycles
)(
  input  wire logic                    i_clock,   // system clock
  input  wire logic                    i_fb_sel,  // 1 = doubled fed back
  input  wire deskew_pkg::clock_outs_t i_clocks,  // loop outputs
  output var  logic                    o_source,  // source clock
  output var  logic                    o_feedback // feedback clock
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial o_source = 1'b0;
  // source from a clock input buffer; it runs free, never parked
  always @(posedge i_clock) begin
    cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    o_source <= cnt < HALF;
  end
  // global buffer return, so no delay is added to the fed-back clock
  assign o_feedback = i_fb_sel ? i_clocks.doubled : i_clocks.deskewed;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the deskew clock loop
`default_nettype none
module tb_top;
  import deskew_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 16; // source period in system cycles
  int tw[8] = '{3, 4, 5, 6, 8, 10, 16, 32}; // twice each divide factor
  int miscompares = 0, checked = 0, cyc = 0;
  logic clk = 1'b0, rst = 1'b1, en = 1'b1, lrst = 1'b0, dce = 1'b1, fsel = 1'b0, lk, src, fb;
  variant_t vr = VARIANT_FULL;
  divide_factor_t df = DIV_2;
  clock_outs_t co;
  initial forever #25 clk = ~clk;
  deskew_clock_dll i_deskew_clock_dll (.i_clock(clk), .i_rst(rst), .i_clk_en(en),
    .i_variant(vr), .i_source_clock_in(src), .i_feedback_clock_in(fb), .i_loop_reset(lrst),
    .i_duty_correct_en(dce), .i_divide_factor_setting(df), .o_clocks(co),
    .o_lock_indicator(lk));
  clock_net_model #(.HALF(P / 2)) i_clock_net_model (.i_clock(clk), .i_fb_sel(fsel),
    .i_clocks(co), .o_source(src), .o_feedback(fb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %0d, expected %0d", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // syncs to a rise, skips one whole period, then times the next one
  task automatic meas_chk(input int b, input int eh, input int el);
    int h, l;
    for (int i = 0; i < 999 && co[b] !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 999 && co[b] !== 1'b1; i++) @(negedge clk);
    repeat (2) begin
      for (h = 0; h < 999 && co[b] === 1'b1; h++) @(negedge clk);
      for (l = 0; l < 999 && co[b] === 1'b0; l++) @(negedge clk);
    end
    check(h, eh);
    check(l, el);
  endtask
  task automatic wait_lock;
    for (int i = 0; i < 40 * P && lk !== 1'b1; i++) @(negedge clk);
    check(32'(lk), 1);
  endtask
  // cycles from a sampled source rise to the deskewed rise
  task automatic skew_chk(input int exp);
    int d;
    for (int i = 0; i < 99 && src !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 99 && src !== 1'b1; i++) @(negedge clk);
    for (d = 0; d < 99 && co.deskewed !== 1'b1; d++) @(negedge clk);
    check(d, exp);
  endtask
  // loop reset held four source periods plus a skew check; lock must be gone after the four
  task automatic relock;
    @(posedge clk) lrst <= 1'b1;
    repeat (LOCK_DROP_SRC * P) @(negedge clk);
    check(32'(lk), 0);
    skew_chk(2);
    @(posedge clk) lrst <= 1'b0;
    repeat (3 * P) @(negedge clk); // taps settle before waveforms are timed
  endtask
  // a hang ends the run through the same report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    relock();
    meas_chk(1, P / 4, 3 * P / 4);
    wait_lock();
    meas_chk(1, P / 4, P / 4);
    skew_chk(0);
    for (int f = 0; f < 8; f++) begin
      @(posedge clk) df <= divide_factor_t'(f);
      meas_chk(0, P * tw[f] / 4, P * tw[f] / 4);
    end
    check(32'(lk), 1);
    $display("test lock and divide done");
    @(posedge clk) fsel <= 1'b1;
    relock();
    wait_lock();
    repeat (4 * P) @(negedge clk);
    check(32'(lk), 1);
    meas_chk(1, P / 4, P / 4);
    skew_chk(0);
    $display("test relock on doubled done");
    @(posedge clk);
    fsel <= 1'b0;
    vr <= VARIANT_HF;
    @(posedge clk);
    for (int i = 0; i < 2 * P; i++) begin
      @(negedge clk);
      check(32'(co.doubled), 0);
    end
    meas_chk(0, P * 8, P * 8);
    $display("test high-freq done");
    @(posedge clk);
    vr <= VARIANT_WRAP;
    lrst <= 1'b1;
    meas_chk(2, P / 2, P / 2);
    check(32'({co.divided, lk}), 0);
    @(posedge clk);
    dce <= 1'b0;
    en <= 1'b0;
    @(posedge clk) en <= 1'b1;
    meas_chk(2, P / 2, P / 2);
    $display("test wrapper done");
    complete_run();
  end
endmodule
`default_nettype wire
